// >>> verilog/gdio_consts.svh
// constants of the general digital I/O port block
`ifndef GDIO_CONSTS_SVH
`define GDIO_CONSTS_SVH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define GDIO_N_PORTS      2
`define GDIO_PW           8
`define GDIO_AW           6
`define GDIO_BIT_IDX_W    3

// ----------------------------------------------------------------------
// I/O space map, three locations per port
// ----------------------------------------------------------------------
`define GDIO_BASE_ADDR    6'h03
`define GDIO_PORT_STRIDE  6'h03
`define GDIO_OFS_SAMPLE   6'h00
`define GDIO_OFS_DIR      6'h01
`define GDIO_OFS_LATCH    6'h02
`define GDIO_PCR_ADDR     6'h12

// ----------------------------------------------------------------------
// port control register fields: pull-up disable in low nibble, bbm above
// ----------------------------------------------------------------------
`define GDIO_PCR_PUD_LSB  0
`define GDIO_PCR_BBM_LSB  4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GDIO_DIR_RST      8'h00
`define GDIO_LATCH_RST    8'h00
`define GDIO_PCR_RST      8'h00
`define GDIO_RDATA_RST    8'h00
`define GDIO_BYTE_ONES    8'hFF

`endif

// >>> verilog/gdio_pkg.sv
// types shared by the general digital I/O port block
`include "gdio_consts.svh"

package gdio_pkg;

   typedef logic [`GDIO_PW-1:0]                 gdio_byte_t;
   typedef logic [`GDIO_AW-1:0]                 gdio_addr_t;
   typedef logic [`GDIO_BIT_IDX_W-1:0]          gdio_bit_idx_t;
   typedef logic [`GDIO_N_PORTS*`GDIO_PW-1:0]   gdio_pins_t;

   // register file of the whole block
   typedef struct packed {
      gdio_byte_t [`GDIO_N_PORTS-1:0] dir;
      gdio_byte_t [`GDIO_N_PORTS-1:0] latch;
      gdio_byte_t                     pcr;
      gdio_byte_t                     rdata;
   } gdio_regs_t;

   // pad drive state of one port
   typedef struct packed {
      gdio_byte_t oe;
      gdio_byte_t out;
      gdio_byte_t pu;
   } gdio_pad_t;

   // which register an I/O access hits
   typedef enum logic [2:0] {
      GDIO_SEL_NONE,
      GDIO_SEL_SAMPLE,
      GDIO_SEL_DIR,
      GDIO_SEL_LATCH,
      GDIO_SEL_PCR
   } gdio_sel_t;

endpackage : gdio_pkg

// >>> verilog/gdio_sync.sv
// input clamp and latch plus flip-flop synchroniser for one port
`timescale 1ns/100ps
`default_nettype none
`include "gdio_consts.svh"

module gdio_sync (
   input  wire logic             CORE_CLK,
   input  wire logic             NRST,
   input  wire logic             clk_en,
   input  wire gdio_pkg::gdio_byte_t pad_in,
   input  wire logic             sleep_clamp,
   input  wire gdio_pkg::gdio_byte_t clamp_override,
   output gdio_pkg::gdio_byte_t  sample
);
   import gdio_pkg::*;

   gdio_byte_t din;
   gdio_byte_t sync_lat;
   gdio_byte_t sample_ff;
   gdio_byte_t nxt_sample;

   // ----------------------------------------------------------------------
   // sleep clamp
   // ----------------------------------------------------------------------
   // floating inputs held low while asleep unless a function needs them
   assign din = pad_in & ~({`GDIO_PW{sleep_clamp}} & ~clamp_override);

   // ----------------------------------------------------------------------
   // synchroniser
   // ----------------------------------------------------------------------
   // open while clock high, closes on falling edge; not frozen by clk_en
   always_latch begin
      if (CORE_CLK) begin
         sync_lat <= din;
      end
   end

   always_comb begin
      nxt_sample = clk_en ? sync_lat : sample_ff;
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         sample_ff <= `GDIO_RDATA_RST;
      end else begin
         sample_ff <= nxt_sample;
      end
   end

   assign sample = sample_ff;

endmodule : gdio_sync

`default_nettype wire

// >>> verilog/gdio_pad_ctrl.sv
// pad drive, pull-up and break-before-make for one port
`timescale 1ns/100ps
`default_nettype none
`include "gdio_consts.svh"

module gdio_pad_ctrl (
   input  wire logic                 CORE_CLK,
   input  wire logic                 NRST,
   input  wire logic                 clk_en,
   input  wire gdio_pkg::gdio_byte_t dir_cur,
   input  wire gdio_pkg::gdio_byte_t dir_nxt,
   input  wire gdio_pkg::gdio_byte_t latch_nxt,
   input  wire logic                 bbm_en,
   input  wire logic                 global_pullup_disable,
   input  wire gdio_pkg::gdio_byte_t alt_override,
   input  wire gdio_pkg::gdio_byte_t alt_oe,
   input  wire gdio_pkg::gdio_byte_t alt_out,
   output gdio_pkg::gdio_byte_t      pad_oe,
   output gdio_pkg::gdio_byte_t      pad_out,
   output gdio_pkg::gdio_byte_t      pad_pu
);
   import gdio_pkg::*;

   gdio_pad_t  pad_ff;
   gdio_pad_t  nxt_pad;
   gdio_byte_t gp_oe;
   gdio_byte_t bbm_hold;

   // ----------------------------------------------------------------------
   // next pad state
   // ----------------------------------------------------------------------
   always_comb begin
      // only an input-to-output change is held off, never the reverse
      bbm_hold    = {`GDIO_PW{bbm_en}} & dir_nxt & ~dir_cur;
      gp_oe       = dir_nxt & ~bbm_hold;
      nxt_pad     = pad_ff;
      if (clk_en) begin
         // overridden pins leave the rest of the port alone
         nxt_pad.oe  = (alt_override & alt_oe) | (~alt_override & gp_oe);
         nxt_pad.out = (alt_override & alt_out) | (~alt_override & latch_nxt);
         nxt_pad.pu  = ~alt_override & ~dir_nxt & latch_nxt
                       & ~{`GDIO_PW{global_pullup_disable}};
      end
   end

   // ----------------------------------------------------------------------
   // pad flops; reset floats every pin without needing a clock
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         pad_ff <= '0;
      end else begin
         pad_ff <= nxt_pad;
      end
   end

   assign pad_oe  = pad_ff.oe;
   assign pad_out = pad_ff.out;
   assign pad_pu  = pad_ff.pu;

endmodule : gdio_pad_ctrl

`default_nettype wire

// >>> verilog/gdio_top.sv
// general digital I/O ports with register access over the I/O space
`timescale 1ns/100ps
`default_nettype none
`include "gdio_consts.svh"

// Overview of operation
// - direction one drives output, zero input
// - input with latch one enables pull-up
// - output drives the latch bit level
// - reset floats all pins without a clock
// - writing one to sample toggles latch
// - latch, direction read/write; sample read-only
// - pull-up disable bits force pull-ups off
// - pull-up only for input, latch one, enabled
// - break-before-make adds one floating cycle
// - break-before-make enabled per port
// - output-to-input adds no floating cycle
// - pin readable via synchroniser any direction
// - latch open clock high, flop next edge
// - pin edge seen after half to 1.5 cycles
// - own write visible one cycle later
// - bit set/clear touches only that bit
// - alternate function pins leave others usable
// - sleep clamps inputs low unless overridden
module gdio_top #(
   parameter logic [`GDIO_AW-1:0] BASE_ADDR = `GDIO_BASE_ADDR
) (
   input  wire logic                   CORE_CLK,
   input  wire logic                   NRST,
   input  wire logic                   CLK_EN,
   input  wire gdio_pkg::gdio_addr_t   IO_ADDR,
   input  wire logic                   IO_WR,
   input  wire logic                   IO_RD,
   input  wire gdio_pkg::gdio_byte_t   IO_WDATA,
   input  wire logic                   IO_BIT_SET,
   input  wire logic                   IO_BIT_CLR,
   input  wire gdio_pkg::gdio_bit_idx_t IO_BIT_IDX,
   output gdio_pkg::gdio_byte_t        IO_RDATA,
   input  wire logic                   GLOBAL_PULLUP_DISABLE,
   input  wire logic                   SLEEP_CLAMP,
   input  wire gdio_pkg::gdio_pins_t   CLAMP_OVERRIDE,
   input  wire gdio_pkg::gdio_pins_t   ALT_OVERRIDE,
   input  wire gdio_pkg::gdio_pins_t   ALT_OE,
   input  wire gdio_pkg::gdio_pins_t   ALT_OUT,
   input  wire gdio_pkg::gdio_pins_t   PAD_IN,
   output gdio_pkg::gdio_pins_t        PAD_OUT,
   output gdio_pkg::gdio_pins_t        PAD_OE,
   output gdio_pkg::gdio_pins_t        PAD_PULLUP
);
   import gdio_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   gdio_regs_t regs_ff;
   gdio_regs_t nxt_regs;

   // ----------------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------------
   gdio_sel_t                      acc_sel;
   logic [`GDIO_N_PORTS-1:0]       acc_port_hit;
   logic                           acc_any;
   gdio_byte_t                     acc_mask;
   gdio_byte_t                     acc_value;
   gdio_byte_t [`GDIO_N_PORTS-1:0] sample;
   gdio_byte_t                     pud_bits;
   gdio_byte_t                     bbm_bits;

   // a full write outranks a bit operation issued in the same cycle
   assign acc_any = IO_WR | IO_BIT_SET | IO_BIT_CLR;

   always_comb begin
      acc_mask  = '0;
      acc_value = '0;
      if (IO_WR) begin
         acc_mask  = `GDIO_BYTE_ONES;
         acc_value = IO_WDATA;
      end else if (IO_BIT_SET) begin
         acc_mask  = gdio_byte_t'(1) << IO_BIT_IDX;
         acc_value = `GDIO_BYTE_ONES;
      end else if (IO_BIT_CLR) begin
         acc_mask  = gdio_byte_t'(1) << IO_BIT_IDX;
         acc_value = '0;
      end
   end

   // per-port address match; one generate so port count scales
   gdio_sel_t [`GDIO_N_PORTS-1:0] port_sel;

   genvar gp;
   generate
      for (gp = 0; gp < `GDIO_N_PORTS; gp = gp + 1) begin : g_dec
         localparam logic [`GDIO_AW-1:0] PBASE =
            BASE_ADDR + `GDIO_AW'(gp * `GDIO_PORT_STRIDE);
         always_comb begin
            if (IO_ADDR == PBASE + `GDIO_OFS_SAMPLE) begin
               port_sel[gp] = GDIO_SEL_SAMPLE;
            end else if (IO_ADDR == PBASE + `GDIO_OFS_DIR) begin
               port_sel[gp] = GDIO_SEL_DIR;
            end else if (IO_ADDR == PBASE + `GDIO_OFS_LATCH) begin
               port_sel[gp] = GDIO_SEL_LATCH;
            end else begin
               port_sel[gp] = GDIO_SEL_NONE;
            end
            acc_port_hit[gp] = (port_sel[gp] != GDIO_SEL_NONE);
         end
      end
   endgenerate

   always_comb begin
      acc_sel = GDIO_SEL_NONE;
      if (IO_ADDR == `GDIO_PCR_ADDR) begin
         acc_sel = GDIO_SEL_PCR;
      end
      for (int i = 0; i < `GDIO_N_PORTS; i++) begin
         if (acc_port_hit[i]) begin
            acc_sel = port_sel[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // port control fields
   // ----------------------------------------------------------------------
   always_comb begin
      pud_bits = '0;
      bbm_bits = '0;
      for (int i = 0; i < `GDIO_N_PORTS; i++) begin
         pud_bits[i] = regs_ff.pcr[`GDIO_PCR_PUD_LSB + i] | GLOBAL_PULLUP_DISABLE;
         bbm_bits[i] = regs_ff.pcr[`GDIO_PCR_BBM_LSB + i];
      end
   end

   // ----------------------------------------------------------------------
   // register file next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_regs = regs_ff;
      if (CLK_EN) begin
         for (int i = 0; i < `GDIO_N_PORTS; i++) begin
            if (acc_any && acc_port_hit[i]) begin
               case (port_sel[i])
                  GDIO_SEL_DIR: begin
                     nxt_regs.dir[i] = (regs_ff.dir[i] & ~acc_mask)
                                       | (acc_value & acc_mask);
                  end
                  GDIO_SEL_LATCH: begin
                     nxt_regs.latch[i] = (regs_ff.latch[i] & ~acc_mask)
                                         | (acc_value & acc_mask);
                  end
                  GDIO_SEL_SAMPLE: begin
                     // sample itself is never written; ones flip the latch
                     nxt_regs.latch[i] = regs_ff.latch[i]
                                         ^ (acc_value & acc_mask);
                  end
                  default: begin
                     nxt_regs.latch[i] = regs_ff.latch[i];
                  end
               endcase
            end
         end
         if (acc_any && acc_sel == GDIO_SEL_PCR) begin
            nxt_regs.pcr = (regs_ff.pcr & ~acc_mask) | (acc_value & acc_mask);
         end
         // read data held until the next read; unmapped reads give zero
         if (IO_RD) begin
            nxt_regs.rdata = `GDIO_RDATA_RST;
            if (acc_sel == GDIO_SEL_PCR) begin
               nxt_regs.rdata = regs_ff.pcr;
            end
            for (int i = 0; i < `GDIO_N_PORTS; i++) begin
               if (acc_port_hit[i]) begin
                  case (port_sel[i])
                     GDIO_SEL_SAMPLE: nxt_regs.rdata = sample[i];
                     GDIO_SEL_DIR:    nxt_regs.rdata = regs_ff.dir[i];
                     GDIO_SEL_LATCH:  nxt_regs.rdata = regs_ff.latch[i];
                     default:         nxt_regs.rdata = `GDIO_RDATA_RST;
                  endcase
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // register file flops
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < `GDIO_N_PORTS; i++) begin
            regs_ff.dir[i]   <= `GDIO_DIR_RST;
            regs_ff.latch[i] <= `GDIO_LATCH_RST;
         end
         regs_ff.pcr   <= `GDIO_PCR_RST;
         regs_ff.rdata <= `GDIO_RDATA_RST;
      end else begin
         regs_ff <= nxt_regs;
      end
   end

   assign IO_RDATA = regs_ff.rdata;

   // ----------------------------------------------------------------------
   // per-port pad control and input synchroniser
   // ----------------------------------------------------------------------
   // pad flops load from next register values so a write shows at its own
   // edge; the pin is then sampled back one period later
   generate
      for (gp = 0; gp < `GDIO_N_PORTS; gp = gp + 1) begin : g_port
         gdio_pad_ctrl u_pad (
            .CORE_CLK     (CORE_CLK),
            .NRST         (NRST),
            .clk_en       (CLK_EN),
            .dir_cur      (regs_ff.dir[gp]),
            .dir_nxt      (nxt_regs.dir[gp]),
            .latch_nxt    (nxt_regs.latch[gp]),
            .bbm_en       (bbm_bits[gp]),
            .global_pullup_disable          (pud_bits[gp]),
            .alt_override (ALT_OVERRIDE[gp*`GDIO_PW +: `GDIO_PW]),
            .alt_oe       (ALT_OE[gp*`GDIO_PW +: `GDIO_PW]),
            .alt_out      (ALT_OUT[gp*`GDIO_PW +: `GDIO_PW]),
            .pad_oe       (PAD_OE[gp*`GDIO_PW +: `GDIO_PW]),
            .pad_out      (PAD_OUT[gp*`GDIO_PW +: `GDIO_PW]),
            .pad_pu       (PAD_PULLUP[gp*`GDIO_PW +: `GDIO_PW])
         );

         gdio_sync u_sync (
            .CORE_CLK       (CORE_CLK),
            .NRST           (NRST),
            .clk_en         (CLK_EN),
            .pad_in         (PAD_IN[gp*`GDIO_PW +: `GDIO_PW]),
            .sleep_clamp    (SLEEP_CLAMP),
            .clamp_override (CLAMP_OVERRIDE[gp*`GDIO_PW +: `GDIO_PW]),
            .sample         (sample[gp])
         );
      end
   endgenerate

endmodule : gdio_top

`default_nettype wire

// >>> test/gdio_top_asserts.sv
// concurrent checks on the ports of the digital I/O port block
`include "gdio_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module gdio_top_asserts #(
   parameter logic [`GDIO_AW-1:0] BASE_ADDR = `GDIO_BASE_ADDR
) (
   input wire logic                 CORE_CLK,
   input wire logic                 NRST,
   input wire logic                 CLK_EN,
   input wire gdio_pkg::gdio_addr_t IO_ADDR,
   input wire logic                 IO_WR,
   input wire logic                 IO_RD,
   input wire gdio_pkg::gdio_byte_t IO_WDATA,
   input wire gdio_pkg::gdio_byte_t IO_RDATA,
   input wire logic                 GLOBAL_PULLUP_DISABLE,
   input wire logic                 SLEEP_CLAMP,
   input wire gdio_pkg::gdio_pins_t ALT_OVERRIDE,
   input wire gdio_pkg::gdio_pins_t PAD_IN,
   input wire gdio_pkg::gdio_pins_t PAD_OUT,
   input wire gdio_pkg::gdio_pins_t PAD_OE,
   input wire gdio_pkg::gdio_pins_t PAD_PULLUP
);
   import gdio_pkg::*;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   a_reset_quiet: assert property ($rose(NRST) |-> PAD_OE == 16'h0000 && PAD_PULLUP == 16'h0000)
      else $error("pins not floating after reset");
   a_pullup_input_only: assert property ((PAD_PULLUP & PAD_OE) == 16'h0000)
      else $error("pull-up on a driven pin");
   a_dir_clear_fast: assert property (IO_WR && CLK_EN && IO_ADDR == BASE_ADDR + 6'h01 |=>
      (PAD_OE[7:0] & ~$past(ALT_OVERRIDE[7:0]) & ~$past(IO_WDATA)) == 8'h00)
      else $error("driver kept after direction cleared");
   a_latch_drives: assert property (IO_WR && CLK_EN && IO_ADDR == BASE_ADDR + 6'h02 |=>
      ((PAD_OUT[7:0] ^ $past(IO_WDATA)) & PAD_OE[7:0] & ~$past(ALT_OVERRIDE[7:0])) == 8'h00)
      else $error("driven level differs from latch");
   a_gpud_off: assert property (GLOBAL_PULLUP_DISABLE && CLK_EN |=> PAD_PULLUP == 16'h0000)
      else $error("pull-up on while disabled");
   a_unmapped_zero: assert property (IO_RD && CLK_EN && IO_ADDR == 6'h3F |=> IO_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!(IO_RD && CLK_EN) |=> $stable(IO_RDATA))
      else $error("read data moved without a read");
   a_pin_sync: assert property (IO_RD && CLK_EN && IO_ADDR == BASE_ADDR && !SLEEP_CLAMP
      && !$past(SLEEP_CLAMP) && $past(CLK_EN) |=> IO_RDATA == $past(PAD_IN[7:0], 2))
      else $error("sampled pins differ from pad level");
   a_freeze_en: assert property (!CLK_EN |=> $stable(PAD_OE) && $stable(PAD_OUT))
      else $error("pads moved while clock enable low");
endmodule : gdio_top_asserts

bind gdio_top gdio_top_asserts #(.BASE_ADDR(BASE_ADDR)) u_chk (
   .CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(CLK_EN), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
   .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
   .GLOBAL_PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE), .SLEEP_CLAMP(SLEEP_CLAMP),
   .ALT_OVERRIDE(ALT_OVERRIDE), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
   .PAD_PULLUP(PAD_PULLUP));
`default_nettype wire

// >>> test/gdio_pads.sv
// pads and board wiring seen at the port pins
`timescale 1ns/100ps
`default_nettype none

module gdio_pads (
   input wire logic                 CORE_CLK,
   input wire gdio_pkg::gdio_pins_t pad_out,
   input wire gdio_pkg::gdio_pins_t pad_oe,
   input wire gdio_pkg::gdio_pins_t pad_pu,
   input wire gdio_pkg::gdio_pins_t ext_en,
   input wire gdio_pkg::gdio_pins_t ext_val,
   output gdio_pkg::gdio_pins_t     pad_in
);
   import gdio_pkg::*;
   gdio_pins_t flt = 16'h5555;
   // undriven pins wander, so a lost driver never reads as a steady level
   always @(posedge CORE_CLK) flt <= ~flt;
   // own driver first, then board, then pull-up
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & (pad_pu | flt));
endmodule : gdio_pads
`default_nettype wire

// >>> test/gdio_top_tb.sv
// self-checking bench of the digital I/O port block
`include "gdio_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module gdio_top_tb;
   import gdio_pkg::*;
   logic       clk = 1'b0, nrst = 1'b0, en = 1'b1, gpud = 1'b0, clamp = 1'b0;
   logic       wr = 1'b0, rd = 1'b0, bset = 1'b0, bclr = 1'b0;
   gdio_addr_t addr = 6'h00;
   gdio_byte_t wdata = 8'h00, rdata, m_pcr, v;
   gdio_byte_t m_dir [2], m_lat [2];
   gdio_bit_idx_t idx = 3'h0;
   // board holds every pin low until the sampling test, so sample reads are defined
   gdio_pins_t clov = '0, alov = '0, aloe = '0, alout = '0, ext_en = 16'hFFFF, ext_val = '0;
   gdio_pins_t pin_in, pout, poe, ppu;
   int         errors = 0, n_tests = 0, cyc = 0, p, o, k;

   gdio_top i_dut (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(en), .IO_ADDR(addr), .IO_WR(wr),
      .IO_RD(rd), .IO_WDATA(wdata), .IO_BIT_SET(bset), .IO_BIT_CLR(bclr), .IO_BIT_IDX(idx),
      .IO_RDATA(rdata), .GLOBAL_PULLUP_DISABLE(gpud), .SLEEP_CLAMP(clamp),
      .CLAMP_OVERRIDE(clov), .ALT_OVERRIDE(alov), .ALT_OE(aloe), .ALT_OUT(alout),
      .PAD_IN(pin_in), .PAD_OUT(pout), .PAD_OE(poe), .PAD_PULLUP(ppu));
   gdio_pads i_pads (.CORE_CLK(clk), .pad_out(pout), .pad_oe(poe), .pad_pu(ppu),
      .ext_en(ext_en), .ext_val(ext_val), .pad_in(pin_in));

   initial forever #12.5 clk = ~clk;
   // a hang ends the run as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic gdio_addr_t adr(input int p, input int o);
      if (o == 3) return `GDIO_PCR_ADDR;
      return `GDIO_BASE_ADDR + `GDIO_PORT_STRIDE * p[5:0] + o[5:0];
   endfunction : adr
   function automatic gdio_byte_t mreg(input int p, input int o);
      return (o == 1) ? m_dir[p] : (o == 2) ? m_lat[p] : m_pcr;
   endfunction : mreg
   // one strobe cycle, then one quiet cycle: keeps direction changes two apart
   task automatic acc(input logic [3:0] s, input gdio_addr_t a, input gdio_byte_t d);
      @(posedge clk);
      {wr, rd, bset, bclr} <= s;
      addr <= a;
      wdata <= d;
      idx <= d[2:0];
      @(posedge clk);
      {wr, rd, bset, bclr} <= 4'h0;
      #1;
   endtask : acc
   task automatic op(input logic [3:0] s, input int p, input int o, input gdio_byte_t d);
      gdio_byte_t m;
      m = 8'h01 << d[2:0];
      acc(s, adr(p, o), d);
      if (s[3]) begin
         if (o == 0) m_lat[p] ^= d;
         if (o == 1) m_dir[p] = d;
         if (o == 2) m_lat[p] = d;
         if (o == 3) m_pcr = d;
      end else if (s[1]) begin
         if (o == 0) m_lat[p] ^= m;
         if (o == 1) m_dir[p] |= m;
         if (o == 2) m_lat[p] |= m;
      end else begin
         if (o == 1) m_dir[p] &= ~m;
         if (o == 2) m_lat[p] &= ~m;
      end
   endtask : op
   task automatic rop(input int p, input int o, input gdio_byte_t e);
      acc(4'h4, adr(p, o), 8'h00);
      chk(rdata, e);
   endtask : rop
   task automatic chk_pads();
      gdio_byte_t global_pullup_disable, ao, oe;
      @(posedge clk);
      #1;
      for (int p = 0; p < 2; p++) begin
         global_pullup_disable = {8{m_pcr[p] | gpud}};
         ao = alov[p*8+:8];
         oe = (m_dir[p] & ~ao) | (aloe[p*8+:8] & ao);
         chk(poe[p*8+:8], oe);
         chk(pout[p*8+:8] & oe, ((m_lat[p] & ~ao) | (alout[p*8+:8] & ao)) & oe);
         chk(ppu[p*8+:8], ~m_dir[p] & m_lat[p] & ~global_pullup_disable & ~ao);
      end
   endtask : chk_pads

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(59));
      m_dir = '{8'h00, 8'h00};
      m_lat = '{8'h00, 8'h00};
      m_pcr = 8'h00;
      // flops take reset at the first edge; the clockless case is checked at the end of the run
      @(posedge clk);
      #1;
      chk(poe | ppu, 16'h0000);
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 1; i < 8; i++) rop(i / 4, i % 4, 8'h00);
      rop(0, 0, 8'h00);
      $display("reset values done");
      repeat (60) begin
         p = $urandom % 2;
         o = $urandom % 4;
         k = $urandom % 3;
         gpud <= ($urandom % 4 == 0);
         op((k == 0 || o == 3) ? 4'h8 : (k == 1 ? 4'h2 : 4'h1), p, o, $urandom);
         chk_pads();
         if (o != 0) rop(p, o, mreg(p, o));
      end
      gpud <= 1'b0;
      $display("random access done");
      op(4'h8, 0, 3, 8'h10);
      op(4'h8, 0, 1, 8'h00);
      op(4'h8, 1, 1, 8'h00);
      op(4'h8, 0, 2, 8'h01);
      op(4'h8, 1, 2, 8'h01);
      // on port 0 a floating cycle sits between pull-up and drive high
      op(4'h8, 0, 1, 8'h01);
      chk(poe[0], 1'b0);
      @(posedge clk);
      #1;
      chk(poe[0], 1'b1);
      op(4'h8, 1, 1, 8'h01);
      chk(poe[8], 1'b1);
      op(4'h8, 0, 1, 8'h00);
      chk(poe[0], 1'b0);
      chk_pads();
      $display("break before make done");
      v = $urandom;
      op(4'h8, 1, 1, 8'hFF);
      @(posedge clk);
      {wr, addr, wdata} <= {1'b1, adr(1, 2), v};
      @(posedge clk);
      // one idle cycle: the pin reaches the sample flop one edge after the write
      wr <= 1'b0;
      @(posedge clk);
      {rd, addr} <= {1'b1, adr(1, 0)};
      @(posedge clk);
      rd <= 1'b0;
      #1;
      m_lat[1] = v;
      chk(rdata, v);
      ext_en <= 16'h00FF;
      ext_val <= $urandom;
      repeat (3) @(posedge clk);
      rop(0, 0, ext_val[7:0]);
      clamp <= 1'b1;
      clov <= 16'h000F;
      repeat (3) @(posedge clk);
      rop(0, 0, ext_val[7:0] & 8'h0F);
      clamp <= 1'b0;
      $display("pin sampling done");
      alov <= 16'h0001;
      aloe <= 16'h0001;
      alout <= 16'h0001;
      repeat (6) begin
         op(4'h8, 0, 1, $urandom);
         chk_pads();
      end
      en <= 1'b0;
      v = m_dir[0];
      op(4'h8, 0, 1, ~v);
      // a write with the clock enable low must leave direction as it was
      m_dir[0] = v;
      en <= 1'b1;
      rop(0, 1, mreg(0, 1));
      acc(4'h4, 6'h3F, 8'h00);
      chk(rdata, 8'h00);
      $display("override and refusal done");
      @(negedge clk);
      nrst = 1'b0;
      #1;
      chk(poe | ppu, 16'h0000);
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rop(1, 1, 8'h00);
      $display("async reset done");
      stop_test();
   end
endmodule : gdio_top_tb
`default_nettype wire
